// ===== axs_defs.vh
// Constants for the per-axis drive and status-one block
`ifndef AXS_DEFS_VH
`define AXS_DEFS_VH
// Register byte offsets
`define AXS_OFF_CMD 6'h00
`define AXS_OFF_STATUS_ONE 6'h04
`define AXS_OFF_MAIN_STATUS 6'h08
`define AXS_OFF_PULSES 6'h0C
`define AXS_OFF_UPPER 6'h10
`define AXS_OFF_LOWER 6'h14
`define AXS_OFF_MODE 6'h18
`define AXS_OFF_POSITION 6'h1C
`define AXS_OFF_IRQ_STATUS 6'h20
`define AXS_OFF_IRQ_MASK 6'h24
// Command op codes, command word bits [6:4]; axis in bits [1:0]
`define AXS_OP_SELECT 3'h0
`define AXS_OP_FIXED_PLUS 3'h1
`define AXS_OP_FIXED_MINUS 3'h2
`define AXS_OP_CONT_PLUS 3'h3
`define AXS_OP_CONT_MINUS 3'h4
`define AXS_OP_DECEL_STOP 3'h5
`define AXS_OP_IMM_STOP 3'h6
// Mode register fields
`define AXS_MODE_SCURVE 0
`define AXS_MODE_SOFTLIM 1
`define AXS_MODE_SLOW_LSB 2
`define AXS_MODE_FAULT_EN 6
// Status-one field positions
`define AXS_ST_CMP_UP 0
`define AXS_ST_CMP_LO 1
`define AXS_ST_ACCEL 2
`define AXS_ST_STEADY 3
`define AXS_ST_DECEL 4
`define AXS_ST_JRISE 5
`define AXS_ST_JFLAT 6
`define AXS_ST_JFALL 7
`define AXS_ST_SLOW_LSB 8
`define AXS_ST_PLIM 12
`define AXS_ST_MLIM 13
`define AXS_ST_FAULT 14
`define AXS_ST_EMG 15
// Reset values
`define AXS_RST_MODE 8'h00
`define AXS_RST_CMP 32'h00000000
`define AXS_RST_MASK 4'h0
// Speed profile
`define AXS_SPD_MAX 8'h40
`define AXS_SPD_QUART 8'h10
`define AXS_CLK_NS 10
`define AXS_RAMP_STEP_NS 1000
`define AXS_RAMP_CYC ((`AXS_RAMP_STEP_NS + `AXS_CLK_NS - 1) / `AXS_CLK_NS)
`endif

// ===== axs_drive_status.v
// Four-axis pulse drive with per-axis status-one word on Avalon-MM
`timescale 1ns/1ps
`default_nettype none
`include "axs_defs.vh"
module axs_drive_status (
   input wire clk_i,                   // System clock, 100 MHz
   input wire reset_n_i,               // Async reset, active low
   input wire ce_i,                    // Clock enable, freezes state
   input wire [5:0] address_i,         // Avalon byte address
   input wire read_i,                  // Avalon read
   input wire write_i,                 // Avalon write
   input wire [31:0] writedata_i,      // Avalon write data
   output reg [31:0] readdata_o,       // Avalon read data
   output reg waitrequest_o,           // Avalon wait request
   input wire [15:0] slowstop_n_i,     // Slow-stop inputs, 4 per axis
   input wire [3:0] plus_limit_n_i,    // Plus limit inputs per axis
   input wire [3:0] minus_limit_n_i,   // Minus limit inputs per axis
   input wire [3:0] servo_fault_n_i,   // Servo fault inputs per axis
   input wire emergency_input_low_i,   // Emergency stop, all axes
   output reg [3:0] pulse_o,           // Drive pulse per axis
   output reg [3:0] dir_o,             // Direction, 1 is minus
   output reg irq_o                    // Level interrupt
);
   integer i;
   integer j;
   // Ramp reload, cut to the tick counter width on purpose
   localparam [31:0] RAMP_FULL = `AXS_RAMP_CYC - 1;
   // Synchronisers
   reg [28:0] sync1_q;
   reg [28:0] sync2_q;
   // Per-axis state
   reg [31:0] pos_q [0:3];
   reg [31:0] upper_q [0:3];
   reg [31:0] lower_q [0:3];
   reg [31:0] remain_q [0:3];
   reg [31:0] ramp_q [0:3];
   reg [7:0] mode_q [0:3];
   reg [7:0] cause_q [0:3];
   reg [7:0] spd_q [0:3];
   reg [7:0] div_q [0:3];
   reg [7:0] tick_q [0:3];
   reg [3:0] run_q;
   reg [3:0] fixed_q;
   reg [3:0] decreq_q;
   reg [3:0] cmp_up_q;
   reg [3:0] cmp_lo_q;
   reg [3:0] run_old_q;
   reg [3:0] irq_st_q;
   reg [3:0] irq_mask_q;
   reg [1:0] sel_q;
   // Synchronised levels, active high
   wire [15:0] slow_act = ~sync2_q[15:0];
   wire [3:0] plim_act = ~sync2_q[19:16];
   wire [3:0] mlim_act = ~sync2_q[23:20];
   wire [3:0] fault_act = ~sync2_q[27:24];
   wire emg_act = ~sync2_q[28];
   // Bus strobes
   wire acc = (read_i | write_i) & ~waitrequest_o;
   wire wr_acc = write_i & ~waitrequest_o;
   wire [2:0] cmd_op = writedata_i[6:4];
   wire [1:0] cmd_ax = writedata_i[1:0];
   wire cmd_wr = wr_acc & (address_i == `AXS_OFF_CMD);
   // Per-axis combinational stop terms
   reg [3:0] hard_stop;
   reg [3:0] soft_hit;
   reg [3:0] slow_hit;
   reg [3:0] decel_now;
   reg [3:0] end_evt;

   ////////////////////////////////////////////////////////////////////
   // Phase and status word helpers
   function [7:0] phase_bits;
      input run;
      input dec;
      input scurve;
      input [7:0] spd;
      reg [2:0] jerk;
      begin
         jerk = 3'h0;
         if (run && scurve && !dec && spd != `AXS_SPD_MAX) begin
            if (spd < `AXS_SPD_QUART)
               jerk = 3'h1;
            else if (spd < `AXS_SPD_MAX - `AXS_SPD_QUART)
               jerk = 3'h2;
            else
               jerk = 3'h4;
         end else if (run && scurve && dec) begin
            if (spd > `AXS_SPD_MAX - `AXS_SPD_QUART)
               jerk = 3'h1;
            else if (spd > `AXS_SPD_QUART)
               jerk = 3'h2;
            else
               jerk = 3'h4;
         end
         phase_bits = {jerk, run & dec, run & ~dec & (spd == `AXS_SPD_MAX),
            run & ~dec & (spd != `AXS_SPD_MAX), 2'h0};
      end
   endfunction

   function [15:0] status_word;
      input [1:0] ax;
      begin
         status_word = {cause_q[ax], phase_bits(run_q[ax], decel_now[ax],
            mode_q[ax][`AXS_MODE_SCURVE], spd_q[ax])}
            | {14'h0000, cmp_lo_q[ax], cmp_up_q[ax]};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers, two flops
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sync1_q <= {29{1'b1}};
         sync2_q <= {29{1'b1}};
      end else if (ce_i) begin
         sync1_q <= {emergency_input_low_i, servo_fault_n_i, minus_limit_n_i,
            plus_limit_n_i, slowstop_n_i};
         sync2_q <= sync1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Stop conditions per axis
   always @* begin
      for (j = 0; j < 4; j = j + 1) begin
         soft_hit[j] = mode_q[j][`AXS_MODE_SOFTLIM] &
            (dir_o[j] ? cmp_lo_q[j] : cmp_up_q[j]);
         hard_stop[j] = run_q[j] & (emg_act | plim_act[j] | mlim_act[j] |
            (fault_act[j] & mode_q[j][`AXS_MODE_FAULT_EN]) | soft_hit[j]);
         slow_hit[j] = run_q[j] &
            (|(slow_act[j*4 +: 4] & mode_q[j][`AXS_MODE_SLOW_LSB +: 4]));
         decel_now[j] = decreq_q[j] | (fixed_q[j] && remain_q[j] <= ramp_q[j]);
         end_evt[j] = run_old_q[j] & ~run_q[j];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Drive engines and per-axis registers
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         for (i = 0; i < 4; i = i + 1) begin
            pos_q[i] <= 32'h00000000;
            upper_q[i] <= `AXS_RST_CMP;
            lower_q[i] <= `AXS_RST_CMP;
            remain_q[i] <= 32'h00000000;
            ramp_q[i] <= 32'h00000000;
            mode_q[i] <= `AXS_RST_MODE;
            cause_q[i] <= 8'h00;
            spd_q[i] <= 8'h00;
            div_q[i] <= 8'h00;
            tick_q[i] <= 8'h00;
         end
         run_q <= 4'h0;
         fixed_q <= 4'h0;
         decreq_q <= 4'h0;
         cmp_up_q <= 4'h0;
         cmp_lo_q <= 4'h0;
         pulse_o <= 4'h0;
         dir_o <= 4'h0;
         sel_q <= 2'h0;
      end else if (ce_i) begin
         for (i = 0; i < 4; i = i + 1) begin
            cmp_up_q[i] <= $signed(pos_q[i]) >= $signed(upper_q[i]);
            cmp_lo_q[i] <= $signed(pos_q[i]) <= $signed(lower_q[i]);
            pulse_o[i] <= 1'b0;
            if (hard_stop[i]) begin
               // latch cause and stop at once
               // causes only ever ORed in here
               run_q[i] <= 1'b0;
               spd_q[i] <= 8'h00;
               cause_q[i] <= cause_q[i] | {emg_act,
                  fault_act[i] & mode_q[i][`AXS_MODE_FAULT_EN],
                  mlim_act[i], plim_act[i], 4'h0};
            end else if (run_q[i]) begin
               if (slow_hit[i]) begin
                  decreq_q[i] <= 1'b1;
                  cause_q[i] <= cause_q[i] |
                     {4'h0, slow_act[i*4 +: 4] & mode_q[i][`AXS_MODE_SLOW_LSB +: 4]};
               end
               // Ramp speed one step per ramp period
               if (tick_q[i] == 8'h00) begin
                  tick_q[i] <= RAMP_FULL[7:0];
                  if (decel_now[i] && spd_q[i] > 8'h01)
                     spd_q[i] <= spd_q[i] - 8'h01;
                  else if (!decel_now[i] && spd_q[i] < `AXS_SPD_MAX)
                     spd_q[i] <= spd_q[i] + 8'h01;
               end else begin
                  tick_q[i] <= tick_q[i] - 8'h01;
               end
               // Pulse generation, period falls as speed rises
               if (div_q[i] == 8'h00) begin
                  div_q[i] <= `AXS_SPD_MAX - spd_q[i];
                  pulse_o[i] <= 1'b1;
                  pos_q[i] <= dir_o[i] ? pos_q[i] - 32'h00000001 : pos_q[i] + 32'h00000001;
                  remain_q[i] <= remain_q[i] - 32'h00000001;
                  if (!decel_now[i] && spd_q[i] != `AXS_SPD_MAX)
                     ramp_q[i] <= ramp_q[i] + 32'h00000001;
                  // last commanded pulse ends the drive
                  if (fixed_q[i] && remain_q[i] == 32'h00000001)
                     run_q[i] <= 1'b0;
                  // Decelerating stop of any drive, on a stop command or slow-stop request, at floor speed
                  if (decreq_q[i] && spd_q[i] == 8'h01)
                     run_q[i] <= 1'b0;
               end else begin
                  div_q[i] <= div_q[i] - 8'h01;
               end
            end
         end
         // Register writes and commands
         if (cmd_wr) begin
            sel_q <= cmd_ax;
            case (cmd_op)
               `AXS_OP_FIXED_PLUS, `AXS_OP_FIXED_MINUS,
               `AXS_OP_CONT_PLUS, `AXS_OP_CONT_MINUS: begin
                  if (!run_q[cmd_ax] &&
                     !(fixed_q[cmd_ax] && remain_q[cmd_ax] == 32'h00000000 &&
                     (cmd_op == `AXS_OP_FIXED_PLUS || cmd_op == `AXS_OP_FIXED_MINUS))) begin
                     run_q[cmd_ax] <= 1'b1;
                     cause_q[cmd_ax] <= 8'h00;
                     spd_q[cmd_ax] <= 8'h01;
                     div_q[cmd_ax] <= `AXS_SPD_MAX - 8'h01;
                     tick_q[cmd_ax] <= RAMP_FULL[7:0];
                     ramp_q[cmd_ax] <= 32'h00000000;
                     decreq_q[cmd_ax] <= 1'b0;
                     fixed_q[cmd_ax] <= (cmd_op == `AXS_OP_FIXED_PLUS) ||
                        (cmd_op == `AXS_OP_FIXED_MINUS);
                     dir_o[cmd_ax] <= (cmd_op == `AXS_OP_FIXED_MINUS) ||
                        (cmd_op == `AXS_OP_CONT_MINUS);
                  end
               end
               `AXS_OP_DECEL_STOP: begin
                  decreq_q[cmd_ax] <= 1'b1;
               end
               `AXS_OP_IMM_STOP: begin
                  run_q[cmd_ax] <= 1'b0;
                  spd_q[cmd_ax] <= 8'h00;
               end
               default: begin
               end
            endcase
         end
         if (wr_acc) begin
            case (address_i)
               `AXS_OFF_PULSES: remain_q[sel_q] <= writedata_i;
               `AXS_OFF_UPPER: upper_q[sel_q] <= writedata_i;
               `AXS_OFF_LOWER: lower_q[sel_q] <= writedata_i;
               `AXS_OFF_MODE: mode_q[sel_q] <= writedata_i[7:0];
               `AXS_OFF_POSITION: begin
                  if (!run_q[sel_q])
                     pos_q[sel_q] <= writedata_i;
               end
               default: begin
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Interrupt status, mask and output
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         run_old_q <= 4'h0;
         irq_st_q <= 4'h0;
         irq_mask_q <= `AXS_RST_MASK;
         irq_o <= 1'b0;
      end else if (ce_i) begin
         run_old_q <= run_q;
         // Set wins over write-one-to-clear
         if (wr_acc && address_i == `AXS_OFF_IRQ_STATUS)
            irq_st_q <= (irq_st_q & ~writedata_i[3:0]) | end_evt;
         else
            irq_st_q <= irq_st_q | end_evt;
         if (wr_acc && address_i == `AXS_OFF_IRQ_MASK)
            irq_mask_q <= writedata_i[3:0];
         irq_o <= |(irq_st_q & irq_mask_q);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Avalon slave: one wait cycle, read data at accept
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         waitrequest_o <= 1'b1;
         readdata_o <= 32'h00000000;
      end else if (ce_i) begin
         if (acc)
            waitrequest_o <= 1'b1;
         else if (read_i | write_i)
            waitrequest_o <= 1'b0;
         if (read_i && waitrequest_o) begin
            case (address_i)
               `AXS_OFF_CMD: readdata_o <= {30'h00000000, sel_q};
               `AXS_OFF_STATUS_ONE: readdata_o <= {16'h0000, status_word(sel_q)};
               `AXS_OFF_MAIN_STATUS: readdata_o <= {24'h000000,
                  |cause_q[3][7:4], |cause_q[2][7:4], |cause_q[1][7:4],
                  |cause_q[0][7:4], run_q};
               `AXS_OFF_PULSES: readdata_o <= remain_q[sel_q];
               `AXS_OFF_UPPER: readdata_o <= upper_q[sel_q];
               `AXS_OFF_LOWER: readdata_o <= lower_q[sel_q];
               `AXS_OFF_MODE: readdata_o <= {24'h000000, mode_q[sel_q]};
               `AXS_OFF_POSITION: readdata_o <= pos_q[sel_q];
               `AXS_OFF_IRQ_STATUS: readdata_o <= {28'h0000000, irq_st_q};
               `AXS_OFF_IRQ_MASK: readdata_o <= {28'h0000000, irq_mask_q};
               default: readdata_o <= 32'h00000000;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ===== axs_drive_status_assertions.sv
// Handshake and hard-stop checks for the drive status block
`timescale 1ns/1ps
`default_nettype none
module axs_drive_status_chk (
   input wire logic clk_i,                   // Clock
   input wire logic reset_n_i,               // Reset, active low
   input wire logic ce_i,                    // Clock enable
   input wire logic read_i,                  // Bus read
   input wire logic write_i,                 // Bus write
   input wire logic [31:0] readdata_o,       // Bus read data
   input wire logic waitrequest_o,           // Bus wait
   input wire logic [3:0] plus_limit_n_i,    // Plus limits
   input wire logic [3:0] minus_limit_n_i,   // Minus limits
   input wire logic emergency_input_low_i,   // Emergency line
   input wire logic [3:0] pulse_o,           // Drive pulses
   input wire logic [3:0] dir_o,             // Directions
   input wire logic irq_o                    // Interrupt
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);
   ////////////////////////////////////////////////////////////
   // Steps of a bus request and of a held stop line
   sequence s_req;
      (read_i || write_i) && waitrequest_o && ce_i;
   endsequence
   sequence s_emg_held;
      !emergency_input_low_i [*6];
   endsequence
   property p_wait_ans;
      s_req |=> !waitrequest_o;
   endproperty
   a_wait_ans: assert property (p_wait_ans) else $error("request not answered");
   property p_wait_one;
      !waitrequest_o && ce_i |=> waitrequest_o;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("wait low too long");
   property p_rd_hold;
      $changed(readdata_o) |-> $past(read_i && waitrequest_o);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   property p_emg;
      s_emg_held |-> pulse_o == 4'h0;
   endproperty
   a_emg: assert property (p_emg) else $error("pulse during emergency");
   property p_plim;
      !plus_limit_n_i[0] [*6] |-> !pulse_o[0];
   endproperty
   a_plim: assert property (p_plim) else $error("pulse at plus limit");
   property p_mlim;
      !minus_limit_n_i[0] [*6] |-> !pulse_o[0];
   endproperty
   a_mlim: assert property (p_mlim) else $error("pulse at minus limit");
   property p_dir;
      $changed(dir_o) |-> $past(write_i && !waitrequest_o);
   endproperty
   a_dir: assert property (p_dir) else $error("direction moved without start");
   property p_rst;
      $rose(reset_n_i) |-> waitrequest_o && !irq_o && pulse_o == 4'h0;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs busy after reset");
endmodule
bind axs_drive_status axs_drive_status_chk u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
   .ce_i(ce_i), .read_i(read_i), .write_i(write_i), .readdata_o(readdata_o),
   .waitrequest_o(waitrequest_o), .plus_limit_n_i(plus_limit_n_i),
   .minus_limit_n_i(minus_limit_n_i), .emergency_input_low_i(emergency_input_low_i),
   .pulse_o(pulse_o), .dir_o(dir_o), .irq_o(irq_o));
`default_nettype wire

// ===== axs_drive_status_tb.sv
// Self-checking bench for the drive status block
`timescale 1ns/1ps
`default_nettype none
`include "axs_defs.vh"
module axs_drive_status_tb;
   typedef struct {logic w; logic [5:0] a; logic [31:0] d; logic [31:0] e;} axs_row_t;
   typedef struct {logic [7:0] mode; logic [7:0] cmd; logic [2:0] trip; logic [15:0] c;} axs_stop_t;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic read_i = 1'b0;
   logic write_i = 1'b0;
   logic [5:0] address_i = 6'h00;
   logic [31:0] writedata_i = 32'h0;
   logic [31:0] readdata_o, npulse, rd;
   logic waitrequest_o, irq_o, emg_n;
   logic [15:0] slow_n;
   logic [3:0] plim_n, mlim_n, fault_n, pulse_o, dir_o;
   logic [2:0] trip = 3'h0;
   int error_cnt = 0;
   int cmp_count = 0;
   // Register accesses with expected read data
   axs_row_t rows [15] = '{'{1'b0, `AXS_OFF_MODE, 32'h0, 32'h0},
      '{1'b0, `AXS_OFF_PULSES, 32'h0, 32'h0}, '{1'b0, `AXS_OFF_STATUS_ONE, 32'h0, 32'h3},
      '{1'b0, 6'h3C, 32'h0, 32'h0}, '{1'b0, `AXS_OFF_MAIN_STATUS, 32'h0, 32'h0},
      '{1'b1, `AXS_OFF_UPPER, 32'h5, 32'h0}, '{1'b0, `AXS_OFF_STATUS_ONE, 32'h0, 32'h2},
      '{1'b1, `AXS_OFF_LOWER, 32'hFFFFFFFF, 32'h0}, '{1'b0, `AXS_OFF_STATUS_ONE, 32'h0, 32'h0},
      '{1'b1, `AXS_OFF_POSITION, 32'h5, 32'h0}, '{1'b0, `AXS_OFF_STATUS_ONE, 32'h0, 32'h1},
      '{1'b1, `AXS_OFF_CMD, 32'h1, 32'h0}, '{1'b0, `AXS_OFF_STATUS_ONE, 32'h0, 32'h3},
      '{1'b0, `AXS_OFF_CMD, 32'h0, 32'h1}, '{1'b1, `AXS_OFF_CMD, 32'h0, 32'h0}};
   // Drive starts and the line or command that ends them
   axs_stop_t stops [7] = '{'{8'h00, 8'h30, 3'h1, 16'h1000}, '{8'h00, 8'h40, 3'h2, 16'h2000},
      '{8'h40, 8'h30, 3'h3, 16'h4000}, '{8'h11, 8'h30, 3'h4, 16'h0400},
      '{8'h00, 8'h40, 3'h5, 16'h8000}, '{8'h01, 8'h30, 3'h6, 16'h0}, '{8'h00, 8'h40, 3'h7, 16'h0}};
   always #5 clk_i = ~clk_i;
   axs_drive_status DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(1'b1), .address_i(address_i),
      .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
      .waitrequest_o(waitrequest_o), .slowstop_n_i(slow_n), .plus_limit_n_i(plim_n),
      .minus_limit_n_i(mlim_n), .servo_fault_n_i(fault_n), .emergency_input_low_i(emg_n),
      .pulse_o(pulse_o), .dir_o(dir_o), .irq_o(irq_o));
   axs_field_model FM (.clk_i(clk_i), .pulse_i(pulse_o), .dir_i(dir_o), .trip_i(trip),
      .slowstop_n_o(slow_n), .plus_limit_n_o(plim_n), .minus_limit_n_o(mlim_n),
      .servo_fault_n_o(fault_n), .emg_n_o(emg_n), .pulse_cnt_o(npulse));
   ////////////////////////////////////////////////////////////
   // Verdict and end of run
   task automatic end_of_test;
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Word compare
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One bus transfer, held until wait is seen low
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      address_i <= a;
      writedata_i <= d;
      write_i <= w;
      read_i <= !w;
      @(posedge clk_i);
      while (waitrequest_o !== 1'b0 && n < 100) begin
         n++;
         @(posedge clk_i);
      end
      rd = readdata_o;
      chk("bus answer", 32'h0, {31'h0, n >= 100});
      write_i <= 1'b0;
      read_i <= 1'b0;
   endtask
   task automatic rchk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk("readback", e, rd & m);
   endtask
   // Poll until axis 0 stops running
   task automatic wait_idle;
      int n;
      n = 0;
      do begin
         bus(1'b0, `AXS_OFF_MAIN_STATUS, 32'h0);
         n++;
      end while (rd[0] !== 1'b0 && n < 400);
      chk("drive ended", 32'h0, {31'h0, rd[0]});
   endtask
   ////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (4) @(posedge clk_i);
      reset_n_i <= 1'b1;
      foreach (rows[i]) begin
         bus(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w) chk("register", rows[i].e, rd);
      end
      // Fixed drive of three steps, then interrupt
      bus(1'b1, `AXS_OFF_PULSES, 32'h3);
      bus(1'b1, `AXS_OFF_CMD, 32'h10);
      rchk(`AXS_OFF_STATUS_ONE, 32'h1C, 32'h4);
      wait_idle();
      chk("steps", 32'h3, npulse);
      rchk(`AXS_OFF_POSITION, 32'hFFFFFFFF, 32'h8);
      chk("irq masked", 32'h0, {31'h0, irq_o});
      bus(1'b1, `AXS_OFF_IRQ_MASK, 32'h1);
      repeat (2) @(posedge clk_i);
      chk("irq raised", 32'h1, {31'h0, irq_o});
      bus(1'b1, `AXS_OFF_IRQ_STATUS, 32'h1);
      repeat (2) @(posedge clk_i);
      chk("irq cleared", 32'h0, {31'h0, irq_o});
      foreach (stops[i]) begin
         bus(1'b1, `AXS_OFF_MODE, {24'h0, stops[i].mode});
         bus(1'b1, `AXS_OFF_CMD, {24'h0, stops[i].cmd});
         repeat (30) @(posedge clk_i);
         rchk(`AXS_OFF_STATUS_ONE, 32'hFFFC, stops[i].mode[0] ? 32'h24 : 32'h4);
         if (stops[i].trip == 3'h6) bus(1'b1, `AXS_OFF_CMD, 32'h60);
         else if (stops[i].trip == 3'h7) bus(1'b1, `AXS_OFF_CMD, 32'h50);
         else trip <= stops[i].trip;
         wait_idle();
         trip <= 3'h0;
         rchk(`AXS_OFF_STATUS_ONE, 32'hFF00, {16'h0, stops[i].c});
         rchk(`AXS_OFF_MAIN_STATUS, 32'hF0, (stops[i].c[15:12] != 0) ? 32'h10 : 32'h0);
      end
      // Fault line ignored while its enable is off
      bus(1'b1, `AXS_OFF_MODE, 32'h0);
      bus(1'b1, `AXS_OFF_CMD, 32'h30);
      trip <= 3'h3;
      repeat (20) @(posedge clk_i);
      rchk(`AXS_OFF_MAIN_STATUS, 32'h1, 32'h1);
      trip <= 3'h0;
      bus(1'b1, `AXS_OFF_CMD, 32'h60);
      wait_idle();
      rchk(`AXS_OFF_STATUS_ONE, 32'hFF00, 32'h0);
      // Soft limit at upper bound ends a plus drive
      bus(1'b1, `AXS_OFF_POSITION, 32'h0);
      bus(1'b1, `AXS_OFF_UPPER, 32'h2);
      bus(1'b1, `AXS_OFF_MODE, 32'h2);
      bus(1'b1, `AXS_OFF_CMD, 32'h30);
      wait_idle();
      rchk(`AXS_OFF_POSITION, 32'hFFFFFFFF, 32'h2);
      rchk(`AXS_OFF_STATUS_ONE, 32'hFF00, 32'h0);
      chk("direction", 32'h0, {31'h0, dir_o[0]});
      end_of_test();
   end
   // Watchdog against a hung handshake or drive
   initial begin
      repeat (50000) @(posedge clk_i);
      error_cnt++;
      end_of_test();
   end
endmodule
`default_nettype wire

// ===== axs_field_model.sv
// Field-side switches, fault line and pulse counter for axis 0
`timescale 1ns/1ps
`default_nettype none
module axs_field_model (
   input wire logic clk_i,              // Clock
   input wire logic [3:0] pulse_i,      // Drive pulses
   input wire logic [3:0] dir_i,        // Direction, 1 is minus
   input wire logic [2:0] trip_i,       // Line to pull low on axis 0
   output logic [15:0] slowstop_n_o,    // Slow-stop switches
   output logic [3:0] plus_limit_n_o,   // Plus limit switches
   output logic [3:0] minus_limit_n_o,  // Minus limit switches
   output logic [3:0] servo_fault_n_o,  // Servo fault lines
   output logic emg_n_o,                // Emergency line
   output logic [31:0] pulse_cnt_o      // Net axis 0 steps
);
   // Open switches rest high on pull-ups
   initial begin
      slowstop_n_o = 16'hFFFF;
      plus_limit_n_o = 4'hF;
      minus_limit_n_o = 4'hF;
      servo_fault_n_o = 4'hF;
      emg_n_o = 1'b1;
      pulse_cnt_o = 32'h0;
   end
   ////////////////////////////////////////////////////////////
   // Close the requested line, count steps by direction
   always @(posedge clk_i) begin
      slowstop_n_o <= (trip_i == 3'h4) ? 16'hFFFB : 16'hFFFF;
      plus_limit_n_o <= {3'h7, trip_i != 3'h1};
      minus_limit_n_o <= {3'h7, trip_i != 3'h2};
      servo_fault_n_o <= {3'h7, trip_i != 3'h3};
      emg_n_o <= trip_i != 3'h5;
      if (pulse_i[0]) begin
         pulse_cnt_o <= pulse_cnt_o + (dir_i[0] ? 32'hFFFFFFFF : 32'h1);
      end
   end
endmodule
`default_nettype wire
